/* File: common/slink_cfg.svh */
// Functional notes
// RULE1: Capture 21 inputs each clock rise, serialize next. Code drops rises that come while the FIFO is full.
// RULE2: Three serial data pairs share the word.
// RULE3: Seven slots per pair, bit 0 first.
// RULE4: Forward clock copy beside the data pairs.
// RULE5: Transmit powerdown releases all serial outputs.
// RULE6: Receive powerdown forces parallel outputs low.
// RULE7: Receiver locks within ten milliseconds.
// RULE8: Receive powerdown complete within one microsecond.
// RULE9: Link period equals strobe period, 15-50 ns. Code needs 7 core cycles per word, 350 ns at 20 MHz.
// RULE10: Seven strobe points spaced across one period.
// RULE11: Receiver presents 21 bits, rising strobe edge.
// RULE12: Source ties unused inputs low.
// RULE13: Input n maps pair n/7, slot n%7.
`ifndef SLINK_CFG_SVH
`define SLINK_CFG_SVH

`define SLINK_WORD_BITS 21
`define SLINK_PAIRS 3
`define SLINK_SLOTS 7
`define SLINK_LAST_SLOT 3'h6
`define SLINK_CLK_HIGH_SLOTS 3'h4
`define SLINK_FIFO_DEPTH 8
`define SLINK_CORE_MHZ 20
`define SLINK_PLL_LOCK_MS 10
`define SLINK_PLL_LOCK_CYCLES (`SLINK_PLL_LOCK_MS * 1000 * `SLINK_CORE_MHZ)
`define SLINK_LOCK_EDGES 4'h4
`define SLINK_LOSS_CYCLES 8'h40
`define SLINK_STROBE_LOW 3'h3

`endif

/* File: common/slink_pkg.sv */
package slink_pkg;
  // Transmit serializer states, Gray coded.
  typedef enum logic [0:0] {
    SLINK_TX_IDLE = 1'b0,
    SLINK_TX_SHIFT = 1'b1
  } slink_tx_state_e;
  // Receive deserializer states, Gray coded.
  typedef enum logic [0:0] {
    SLINK_RX_WAIT = 1'b0,
    SLINK_RX_SAMPLE = 1'b1
  } slink_rx_state_e;
  typedef logic [2:0] slink_slot_t;
endpackage

/* File: hdl/slink_fifo.sv */
// Small synchronous FIFO; ready and valid are honest from the count.
module slink_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] fifo_data_in,
  input wire logic fifo_valid_in,
  output logic fifo_ready_out,
  output logic [WIDTH-1:0] fifo_data_out,
  output logic fifo_valid_out,
  input wire logic fifo_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign fifo_ready_out = (count != FULL_COUNT);
  assign fifo_valid_out = (count != '0);
  assign fifo_data_out = mem[rd_ptr];
  assign push = fifo_valid_in && fifo_ready_out;
  assign pop = fifo_valid_out && fifo_ready_in;

  // Pointers wrap at the depth so a non-power-of-two depth still works.
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; only the pointers give it meaning.
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= fifo_data_in;
    end
  end
endmodule

/* File: hdl/slink_top.sv */
`include "slink_cfg.svh"

// Transmit and receive ends of the seven-to-one serial link.
module slink_top
  import slink_pkg::*;
#(
  parameter int LOCK_LIMIT_CYCLES = `SLINK_PLL_LOCK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tx_parallel_clock_in,
  input wire logic [`SLINK_WORD_BITS-1:0] tx_parallel_in,
  input wire logic tx_powerdown_n_in,
  output logic [`SLINK_PAIRS-1:0] tx_serial_pair_out,
  output logic tx_serial_oe_out,
  output logic tx_forwarded_clock_out,
  output logic tx_fifo_ready_out,
  input wire logic [`SLINK_PAIRS-1:0] rx_serial_pair_in,
  input wire logic rx_forwarded_clock_in,
  input wire logic rx_powerdown_n_in,
  output logic [`SLINK_WORD_BITS-1:0] rx_parallel_out,
  output logic rx_strobe_clock_out,
  output logic rx_locked_out,
  output logic rx_lock_timeout_out
);
  localparam int W = `SLINK_WORD_BITS;
  localparam int P = `SLINK_PAIRS;

  // Two-stage synchronisers for every pin; stage one feeds stage two only.
  logic [W+1:0] tx_meta;
  logic [W+1:0] tx_sync;
  logic [P+1:0] rx_meta;
  logic [P+1:0] rx_sync;
  logic tx_clk_prev;
  logic rx_clk_prev;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_meta <= '0;
      tx_sync <= '0;
      rx_meta <= '0;
      rx_sync <= '0;
      tx_clk_prev <= 1'b0;
      rx_clk_prev <= 1'b0;
    end else begin
      tx_meta <= {tx_powerdown_n_in, tx_parallel_clock_in, tx_parallel_in};
      tx_sync <= tx_meta;
      rx_meta <= {rx_powerdown_n_in, rx_forwarded_clock_in, rx_serial_pair_in};
      rx_sync <= rx_meta;
      tx_clk_prev <= tx_sync[W];
      rx_clk_prev <= rx_sync[P];
    end
  end

  logic [W-1:0] tx_word_sync;
  logic tx_pd_n;
  logic tx_clk_rise;
  logic [P-1:0] rx_bits;
  logic rx_pd_n;
  logic rx_clk_rise;
  assign tx_word_sync = tx_sync[W-1:0];
  assign tx_pd_n = tx_sync[W+1];
  assign tx_clk_rise = tx_sync[W] && !tx_clk_prev;
  assign rx_bits = rx_sync[P-1:0];
  assign rx_pd_n = rx_sync[P+1];
  assign rx_clk_rise = rx_sync[P] && !rx_clk_prev;

  // Words captured while the queue is full are lost; the ready port warns the source.
  logic fifo_in_ready;
  logic [W-1:0] fifo_word;
  logic fifo_out_valid;
  logic tx_pop;
  logic tx_push;
  // RULE1: capture each rise.
  assign tx_push = tx_clk_rise && tx_pd_n;

  slink_fifo #(
    .WIDTH(W),
    .DEPTH(`SLINK_FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .fifo_data_in(tx_word_sync),
    .fifo_valid_in(tx_push),
    .fifo_ready_out(fifo_in_ready),
    .fifo_data_out(fifo_word),
    .fifo_valid_out(fifo_out_valid),
    .fifo_ready_in(tx_pop)
  );

  // Transmit serializer state.
  slink_tx_state_e tx_state;
  slink_tx_state_e next_tx_state;
  slink_slot_t tx_slot;
  slink_slot_t next_tx_slot;
  logic [W-1:0] tx_word;
  logic [W-1:0] next_tx_word;
  logic [P-1:0] next_tx_pair;
  logic next_tx_oe;
  logic next_tx_fwd;

  // A new word is taken in idle or on the last slot, so words run back to back.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_slot = tx_slot;
    next_tx_word = tx_word;
    tx_pop = 1'b0;
    next_tx_pair = '0;
    next_tx_fwd = 1'b0;
    // RULE5: release outputs in powerdown.
    next_tx_oe = tx_pd_n;
    if (!tx_pd_n) begin
      next_tx_state = SLINK_TX_IDLE;
      next_tx_slot = '0;
    end else begin
      if (tx_state == SLINK_TX_SHIFT) begin
        // RULE13: pair n/7, slot n%7.
        for (int p = 0; p < P; p++) begin
          next_tx_pair[p] = tx_word[p * `SLINK_SLOTS + int'(tx_slot)];
        end
        // RULE4: forwarded clock copy.
        next_tx_fwd = (tx_slot < `SLINK_CLK_HIGH_SLOTS);
      end
      // RULE3: seven slots then next.
      if (tx_state == SLINK_TX_IDLE || tx_slot == `SLINK_LAST_SLOT) begin
        tx_pop = fifo_out_valid;
        next_tx_slot = '0;
        next_tx_state = fifo_out_valid ? SLINK_TX_SHIFT : SLINK_TX_IDLE;
        if (fifo_out_valid) begin
          next_tx_word = fifo_word;
        end
      end else begin
        next_tx_slot = tx_slot + 3'h1;
      end
    end
  end

  // RULE2: three pairs driven.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state <= SLINK_TX_IDLE;
      tx_slot <= '0;
      tx_word <= '0;
      tx_serial_pair_out <= '0;
      tx_serial_oe_out <= 1'b0;
      tx_forwarded_clock_out <= 1'b0;
      tx_fifo_ready_out <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_slot <= next_tx_slot;
      tx_word <= next_tx_word;
      tx_serial_pair_out <= next_tx_pair;
      tx_serial_oe_out <= next_tx_oe;
      tx_forwarded_clock_out <= next_tx_fwd;
      tx_fifo_ready_out <= fifo_in_ready;
    end
  end

  // Receive deserializer and lock tracking state.
  slink_rx_state_e rx_state;
  slink_rx_state_e next_rx_state;
  slink_slot_t rx_slot;
  slink_slot_t next_rx_slot;
  logic [W-1:0] rx_acc;
  logic [W-1:0] next_rx_acc;
  logic [3:0] lock_edges;
  logic [3:0] next_lock_edges;
  logic [7:0] gap_cnt;
  logic [7:0] next_gap_cnt;
  logic [31:0] lock_timer;
  logic [31:0] next_lock_timer;
  logic [2:0] strobe_cnt;
  logic [2:0] next_strobe_cnt;
  logic [W-1:0] next_rx_out;
  logic next_strobe;
  logic next_locked;
  logic next_timeout;
  logic word_done;

  // Sampling starts in the cycle the forwarded clock rise is seen, one slot per cycle.
  always_comb begin
    next_rx_state = rx_state;
    next_rx_slot = rx_slot;
    next_rx_acc = rx_acc;
    word_done = 1'b0;
    // RULE10: successive strobe points.
    if (rx_clk_rise) begin
      next_rx_state = SLINK_RX_SAMPLE;
      next_rx_slot = 3'h1;
      for (int p = 0; p < P; p++) begin
        next_rx_acc[p * `SLINK_SLOTS] = rx_bits[p];
      end
    end else if (rx_state == SLINK_RX_SAMPLE) begin
      // RULE13: inverse slot mapping.
      for (int p = 0; p < P; p++) begin
        next_rx_acc[p * `SLINK_SLOTS + int'(rx_slot)] = rx_bits[p];
      end
      if (rx_slot == `SLINK_LAST_SLOT) begin
        word_done = 1'b1;
        next_rx_state = SLINK_RX_WAIT;
        next_rx_slot = '0;
      end else begin
        next_rx_slot = rx_slot + 3'h1;
      end
    end
  end

  // Lock needs a run of regular edges; a long gap means the clock has stopped.
  always_comb begin
    next_lock_edges = lock_edges;
    next_gap_cnt = gap_cnt;
    next_lock_timer = lock_timer;
    next_timeout = rx_lock_timeout_out;
    if (rx_clk_rise) begin
      next_gap_cnt = '0;
      if (lock_edges != `SLINK_LOCK_EDGES) begin
        next_lock_edges = lock_edges + 4'h1;
      end
    end else if (gap_cnt == `SLINK_LOSS_CYCLES) begin
      next_lock_edges = '0;
    end else begin
      next_gap_cnt = gap_cnt + 8'h01;
    end
    if (!rx_pd_n) begin
      next_lock_edges = '0;
    end
    next_locked = (next_lock_edges == `SLINK_LOCK_EDGES);
    // RULE7: lock time watchdog.
    if (next_locked || !rx_pd_n) begin
      next_lock_timer = '0;
      next_timeout = 1'b0;
    end else if (lock_timer >= 32'(LOCK_LIMIT_CYCLES)) begin
      next_timeout = 1'b1;
    end else begin
      next_lock_timer = lock_timer + 32'h0000_0001;
    end
  end

  // Output word and strobe clock; one strobe period per link period.
  always_comb begin
    next_rx_out = rx_parallel_out;
    next_strobe = rx_strobe_clock_out;
    next_strobe_cnt = strobe_cnt;
    if (!rx_pd_n) begin
      // RULE6: outputs forced low.
      // RULE8: entry within a few cycles.
      next_rx_out = '0;
      next_strobe = 1'b0;
      next_strobe_cnt = '0;
    end else if (word_done && rx_locked_out) begin
      // RULE11: data then rising strobe.
      next_rx_out = next_rx_acc;
      next_strobe = 1'b0;
      next_strobe_cnt = `SLINK_STROBE_LOW;
    end else if (strobe_cnt != '0) begin
      next_strobe_cnt = strobe_cnt - 3'h1;
      // RULE9: strobe period follows link.
      if (strobe_cnt == 3'h1) begin
        next_strobe = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_state <= SLINK_RX_WAIT;
      rx_slot <= '0;
      rx_acc <= '0;
      lock_edges <= '0;
      gap_cnt <= '0;
      lock_timer <= '0;
      strobe_cnt <= '0;
      rx_parallel_out <= '0;
      rx_strobe_clock_out <= 1'b0;
      rx_locked_out <= 1'b0;
      rx_lock_timeout_out <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_slot <= next_rx_slot;
      rx_acc <= next_rx_acc;
      lock_edges <= next_lock_edges;
      gap_cnt <= next_gap_cnt;
      lock_timer <= next_lock_timer;
      strobe_cnt <= next_strobe_cnt;
      rx_parallel_out <= next_rx_out;
      rx_strobe_clock_out <= next_strobe;
      rx_locked_out <= next_locked;
      rx_lock_timeout_out <= next_timeout;
    end
  end
endmodule

/* File: test/slink_checker.sv */
`include "slink_cfg.svh"

// Port watcher; every figure here follows the hand-over timing of the link.
module slink_checker #(
  parameter int LOCK_LIMIT_CYCLES = 200
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic tx_parallel_clock_in,
  input wire logic [`SLINK_WORD_BITS-1:0] tx_parallel_in,
  input wire logic tx_powerdown_n_in,
  input wire logic [`SLINK_PAIRS-1:0] tx_serial_pair_out,
  input wire logic tx_serial_oe_out,
  input wire logic tx_forwarded_clock_out,
  input wire logic tx_fifo_ready_out,
  input wire logic [`SLINK_PAIRS-1:0] rx_serial_pair_in,
  input wire logic rx_forwarded_clock_in,
  input wire logic rx_powerdown_n_in,
  input wire logic [`SLINK_WORD_BITS-1:0] rx_parallel_out,
  input wire logic rx_strobe_clock_out,
  input wire logic rx_locked_out,
  input wire logic rx_lock_timeout_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // Pins pass two sync stages and a register, so powerdown bites on the third edge.
  a_pd_release: assert property (!tx_powerdown_n_in [*4] |-> !tx_serial_oe_out)
    else $error("serial outputs still driven in powerdown");
  a_hiz_quiet: assert property (!tx_serial_oe_out |->
    tx_serial_pair_out == '0 && !tx_forwarded_clock_out)
    else $error("released outputs not quiet");
  a_fwd_high: assert property ($rose(tx_forwarded_clock_out) |->
    tx_forwarded_clock_out [*4] ##1 !tx_forwarded_clock_out)
    else $error("forwarded clock high time wrong");
  a_fwd_low: assert property ($fell(tx_forwarded_clock_out) |->
    !tx_forwarded_clock_out [*3])
    else $error("forwarded clock low time wrong");
  a_fwd_enabled: assert property (tx_forwarded_clock_out |-> tx_serial_oe_out)
    else $error("forwarded clock while released");
  a_rx_pd_low: assert property (!rx_powerdown_n_in [*4] |-> rx_parallel_out == '0
    && !rx_strobe_clock_out && !rx_locked_out)
    else $error("receive outputs not low in powerdown");
  a_strobe_gap: assert property ($fell(rx_strobe_clock_out) && rx_locked_out |->
    !rx_strobe_clock_out [*3] ##1 rx_strobe_clock_out)
    else $error("strobe low time wrong");
  a_data_quiet: assert property ($changed(rx_parallel_out) |-> !rx_strobe_clock_out)
    else $error("data changed while strobe high");
  a_strobe_locked: assert property ($rose(rx_strobe_clock_out) |-> rx_locked_out)
    else $error("word presented while unlocked");

  // Cycles spent unlocked; the watchdog must not fire before its limit.
  int unlocked_cycles;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unlocked_cycles <= 0;
    end else begin
      unlocked_cycles <= rx_locked_out ? 0 : unlocked_cycles + 1;
    end
  end

  a_timeout_late: assert property ($rose(rx_lock_timeout_out) |->
    unlocked_cycles >= LOCK_LIMIT_CYCLES)
    else $error("lock timeout raised early");
  a_locked_no_tmo: assert property (rx_locked_out |-> !rx_lock_timeout_out)
    else $error("timeout shown while locked");

  c_frame: cover property ($rose(tx_forwarded_clock_out));
  c_word: cover property ($rose(rx_strobe_clock_out));
  c_full: cover property (!tx_fifo_ready_out);
  c_timeout: cover property ($rose(rx_lock_timeout_out));
endmodule

bind slink_top slink_checker #(.LOCK_LIMIT_CYCLES(LOCK_LIMIT_CYCLES)) chk_u (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .tx_parallel_clock_in(tx_parallel_clock_in), .tx_parallel_in(tx_parallel_in),
  .tx_powerdown_n_in(tx_powerdown_n_in), .tx_serial_pair_out(tx_serial_pair_out),
  .tx_serial_oe_out(tx_serial_oe_out), .tx_forwarded_clock_out(tx_forwarded_clock_out),
  .tx_fifo_ready_out(tx_fifo_ready_out), .rx_serial_pair_in(rx_serial_pair_in),
  .rx_forwarded_clock_in(rx_forwarded_clock_in), .rx_powerdown_n_in(rx_powerdown_n_in),
  .rx_parallel_out(rx_parallel_out), .rx_strobe_clock_out(rx_strobe_clock_out),
  .rx_locked_out(rx_locked_out), .rx_lock_timeout_out(rx_lock_timeout_out)
);

/* File: test/slink_src.sv */
// Parallel source; its clock stands low between words, as a real source may.
module slink_src (
  input wire logic core_clk_in,
  output logic tx_parallel_clock_out,
  output logic [20:0] tx_parallel_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_parallel_clock_out = 1'b0;
    tx_parallel_out = 21'h00_0000;
  end
  // One word per period; data is inverted after the hold so stale values never pass.
  // source word timing
  task automatic send(input logic [20:0] w, input int half);
    @(posedge core_clk_in);
    #2 tx_parallel_out = w;
    // Low and high phases each last half cycles, so the period is twice half.
    repeat (half - 1) @(posedge core_clk_in);
    #2 tx_parallel_clock_out = 1'b1;
    @(posedge core_clk_in);
    #2 tx_parallel_out = ~w;
    repeat (half - 1) @(posedge core_clk_in);
    #2 tx_parallel_clock_out = 1'b0;
  endtask
endmodule

/* File: test/serial_21bit_link_7to1_test.sv */
module serial_21bit_link_7to1_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in, resetn_in, tclk, tpd_n, rpd_n, oe, fwd, rdy, strobe, locked, tmo;
  logic [20:0] tword, rword;
  logic [2:0] txd, rxd;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  logic [20:0] got_q[$];
  time strobe_t[$];

  // Released pairs show a toggling level so a stale value cannot pass.
  assign rxd = oe ? txd : {3{cyc[0]}};

  slink_src src_u (.core_clk_in(core_clk_in), .tx_parallel_clock_out(tclk),
    .tx_parallel_out(tword));
  slink_top #(.LOCK_LIMIT_CYCLES(200)) dut_u (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .tx_parallel_clock_in(tclk), .tx_parallel_in(tword),
    .tx_powerdown_n_in(tpd_n), .tx_serial_pair_out(txd), .tx_serial_oe_out(oe),
    .tx_forwarded_clock_out(fwd), .tx_fifo_ready_out(rdy), .rx_serial_pair_in(rxd),
    .rx_forwarded_clock_in(oe & fwd), .rx_powerdown_n_in(rpd_n),
    .rx_parallel_out(rword), .rx_strobe_clock_out(strobe), .rx_locked_out(locked),
    .rx_lock_timeout_out(tmo));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // Cycle ceiling cuts a hang short.
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // Presented words are collected at each strobe rise.
  always @(posedge strobe) begin
    got_q.push_back(rword);
    strobe_t.push_back($time);
  end

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Samples land two time units after the edge, once its updates have settled.
  task automatic tick();
    @(posedge core_clk_in);
    #2;
  endtask

  // Rebuilds one word from the seven slots of the three pairs.
  task automatic grab(output logic [20:0] w);
    int n;
    n = 0;
    w = '0;
    while (fwd !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk(21'(oe), 21'h1);
    for (int k = 0; k < 7; k++) begin
      for (int p = 0; p < 3; p++) w[p * 7 + k] = txd[p];
      tick();
    end
  endtask

  task automatic run_wire();
    logic [20:0] w[4] = '{21'h00_0001, 21'h00_0080, 21'h10_0000, 21'h0A_AAAA};
    logic [20:0] g;
    foreach (w[i]) begin
      fork
        src_u.send(w[i], 4);
        grab(g);
      join
      chk(g, w[i]);
    end
  endtask

  task automatic run_loop();
    logic [20:0] w[3] = '{21'h12_3456, 21'h0E_DCBA, 21'h1F_FFFF};
    // The last word of the previous scenario is presented late; let it pass first.
    repeat (8) tick();
    got_q.delete();
    strobe_t.delete();
    foreach (w[i]) src_u.send(w[i], 4);
    for (int n = 0; n < 40 && got_q.size() < 3; n++) tick();
    chk(21'(got_q.size()), 21'h3);
    foreach (w[i]) chk(got_q[i], w[i]);
    chk(21'(strobe_t[2] - strobe_t[1]), 21'h00_0190);
  endtask

  task automatic run_rxpd();
    rpd_n = 1'b0;
    repeat (20) tick();
    chk(rword, 21'h00_0000);
    chk(21'({strobe, locked}), 21'h0);
    rpd_n = 1'b1;
    repeat (220) tick();
    chk(21'(tmo), 21'h1);
    repeat (5) src_u.send(21'h05_A5A5, 4);
    repeat (15) tick();
    chk(21'(locked), 21'h1);
  endtask

  task automatic run_txpd();
    int hits;
    hits = 0;
    tpd_n = 1'b0;
    repeat (5) tick();
    chk(21'({txd, oe, fwd}), 21'h0);
    fork
      src_u.send(21'h1F_0F0F, 4);
      repeat (20) begin
        tick();
        hits += (fwd !== 1'b0 || oe !== 1'b0);
      end
    join
    chk(21'(hits), 21'h0);
    tpd_n = 1'b1;
    repeat (4) tick();
  endtask

  // Words arrive faster than the serializer drains, so the buffer must refuse.
  task automatic run_fifo();
    int full;
    int idle;
    full = 0;
    idle = 0;
    fork
      repeat (24) src_u.send(21'h15_5555, 2);
      repeat (96) begin
        tick();
        full += (rdy === 1'b0);
      end
    join
    chk(21'(full > 0), 21'h1);
    for (int n = 0; n < 200 && idle < 8; n++) begin
      tick();
      idle = fwd ? 0 : idle + 1;
    end
    chk(21'(rdy), 21'h1);
  endtask

  initial begin
    resetn_in = 1'b0;
    tpd_n = 1'b1;
    rpd_n = 1'b1;
    repeat (4) @(posedge core_clk_in);
    #2 resetn_in = 1'b1;
    tick();
    chk(21'(rdy), 21'h1);
    run_wire();
    run_loop();
    run_rxpd();
    run_txpd();
    run_fifo();
    report_and_stop();
  end
endmodule
